// ---- dsmd_datapath.sv ----
// Function
// - quad byte sign shift, three-bit amount
// - pair halfword sign shift, four-bit amount
// - word sign shift, five-bit amount
// - rounding adds one at top discarded bit
// - bit 31 extends into upper word
// - unsigned byte times halfword, saturate 0xffff
// - q15 product plus 0x8000, keep upper half
// - minus one squared gives q15 maximum
// - base pair free, extra accumulators untouched
// - q15 to q31 doubled, saturate minus one
// - unsigned byte dot product added to accumulator
// - unsigned byte dot product subtracted
// - signed halfword dot product accumulated
`timescale 1ns/100ps
`include "dsmd_params.svh"
module dsmd_datapath
   import dsmd_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic ce_in,                 // freezes all state when low, except that a reset still clears it
   input wire dsmd_req_s req_in,           // operation and operands
   input wire logic [63:0] acc_rd_in,      // selected accumulator value
   output dsmd_rsp_s rsp_out               // registered result
);
   dsmd_rsp_s rsp_reg;   // result register
   dsmd_rsp_s rsp_next;  // next result

   // arithmetic right shift with optional rounding on a 32-bit sign-extended element
   function automatic logic [31:0] sra_rnd(input logic [31:0] v, input logic [4:0] sh,
                                           input logic rnd);
      logic [32:0] t;
      // widen by one bit so the rounding add cannot overflow
      t = {v[31], v};
      // the rounding one lands on the highest bit that is shifted out
      if (rnd && sh != 5'h00)
      begin
         t = t + (33'h000000001 << (sh - 5'h01));
      end
      // sign bit is copied into the vacated positions
      t = $signed(t) >>> sh;
      sra_rnd = t[31:0];
   endfunction

   // q15 times q15 doubled into q31, saturating the minus one case
   function automatic logic [31:0] q15_mul(input logic [15:0] a, input logic [15:0] b);
      logic [31:0] p;
      p = 32'($signed(a) * $signed(b));
      // only minus one times minus one overflows the doubled product
      if (a == `DSMD_Q15_MIN && b == `DSMD_Q15_MIN)
         q15_mul = `DSMD_Q31_MAX;
      else
         q15_mul = {p[30:0], 1'b0};
   endfunction

   // clamp an unsigned byte-by-halfword product to sixteen bits
   function automatic logic [15:0] sat_u16(input logic [23:0] v);
      // anything above the halfword range pins to all ones
      if (v > `DSMD_U16_MAX)
         sat_u16 = 16'hffff;
      else
         sat_u16 = v[15:0];
   endfunction

   // pick one byte of a word: left takes the upper pair, right the lower, hi the odd byte
   function automatic logic [7:0] pick_byte(input logic [31:0] w, input logic lft,
                                            input logic hi);
      // one case arm per byte lane
      case ({lft, hi})
         2'b00: pick_byte = w[7:0];
         2'b01: pick_byte = w[15:8];
         2'b10: pick_byte = w[23:16];
         default: pick_byte = w[31:24];
      endcase
   endfunction

   // result computation
   always_comb
   begin
      logic [4:0] amt;
      logic [31:0] res;
      logic [31:0] e;
      logic [7:0] ba0;
      logic [7:0] ba1;
      logic [7:0] bb0;
      logic [7:0] bb1;
      logic [23:0] up;
      logic [31:0] qp;
      logic [63:0] dsum;
      logic [31:0] hp0;
      logic [31:0] hp1;
      // shift amount comes from the immediate or from the low bits of source a
      amt = req_in.use_imm ? req_in.shift_amount_imm : req_in.source_a_reg[4:0];
      res = 32'h00000000;
      e = 32'h00000000;
      up = 24'h000000;
      qp = 32'h00000000;
      dsum = 64'h0000000000000000;
      hp0 = 32'h00000000;
      hp1 = 32'h00000000;
      // left picks the upper byte pair, right the lower
      ba0 = pick_byte(req_in.source_a_reg, req_in.left, 1'b0);
      ba1 = pick_byte(req_in.source_a_reg, req_in.left, 1'b1);
      bb0 = pick_byte(req_in.source_b_reg, req_in.left, 1'b0);
      bb1 = pick_byte(req_in.source_b_reg, req_in.left, 1'b1);
      // default to an idle response that writes nothing
      rsp_next = '0;
      rsp_next.acc_sel = req_in.acc_sel;
      // decode the operation
      case (req_in.op)
         // four independent byte shifts
         DSMD_OP_SRA_QB:
         begin
            for (int i = 0; i < 4; i++)
            begin
               e = sra_rnd({{24{req_in.source_b_reg[8*i+7]}}, req_in.source_b_reg[8*i +: 8]},
                           {2'b00, amt[2:0]}, req_in.round);
               res[8*i +: 8] = e[7:0];
            end
            rsp_next.gpr_we = req_in.valid;
         end

         // two independent halfword shifts
         DSMD_OP_SRA_PH:
         begin
            for (int i = 0; i < 2; i++)
            begin
               e = sra_rnd({{16{req_in.source_b_reg[16*i+15]}}, req_in.source_b_reg[16*i +: 16]},
                           {1'b0, amt[3:0]}, req_in.round);
               res[16*i +: 16] = e[15:0];
            end
            rsp_next.gpr_we = req_in.valid;
         end

         // one word shift
         DSMD_OP_SRA_W:
         begin
            res = sra_rnd(req_in.source_b_reg, amt, req_in.round);
            rsp_next.gpr_we = req_in.valid;
         end

         // byte pair times both halfwords, saturating
         DSMD_OP_MUL_UBH:
         begin
            up = 24'(ba0 * req_in.source_b_reg[15:0]);
            res[15:0] = sat_u16(up);
            up = 24'(ba1 * req_in.source_b_reg[31:16]);
            res[31:16] = sat_u16(up);
            rsp_next.gpr_we = req_in.valid;
         end

         // two rounded fractional products, accumulators untouched
         DSMD_OP_MUL_QRS:
         begin
            for (int i = 0; i < 2; i++)
            begin
               qp = q15_mul(req_in.source_a_reg[16*i +: 16], req_in.source_b_reg[16*i +: 16]);
               // the clamped case skips the rounding add
               if (qp == `DSMD_Q31_MAX)
                  res[16*i +: 16] = `DSMD_Q15_MAX;
               else
               begin
                  qp = qp + `DSMD_Q15_RND;
                  res[16*i +: 16] = qp[31:16];
               end
            end
            rsp_next.gpr_we = req_in.valid;
         end

         // one doubled fractional product from the chosen halfwords
         DSMD_OP_MUL_QW:
         begin
            res = req_in.left ?
                  q15_mul(req_in.source_a_reg[31:16], req_in.source_b_reg[31:16]) :
                  q15_mul(req_in.source_a_reg[15:0], req_in.source_b_reg[15:0]);
            rsp_next.gpr_we = req_in.valid;
         end

         // unsigned byte dot product into or out of the accumulator
         DSMD_OP_DOT_UADD, DSMD_OP_DOT_USUB:
         begin
            // the byte sum fits in seventeen bits and is zero extended
            dsum = {47'h0, 17'(16'(ba0 * bb0) + 16'(ba1 * bb1))};
            if (req_in.op == DSMD_OP_DOT_UADD)
               rsp_next.acc_data = acc_rd_in + dsum;
            else
               rsp_next.acc_data = acc_rd_in - dsum;
            rsp_next.acc_we = req_in.valid;
         end

         // signed halfword dot product into the accumulator
         DSMD_OP_DOT_SADD:
         begin
            // word products are sign extended before the add
            hp0 = 32'($signed(req_in.source_a_reg[15:0]) * $signed(req_in.source_b_reg[15:0]));
            hp1 = 32'($signed(req_in.source_a_reg[31:16]) * $signed(req_in.source_b_reg[31:16]));
            dsum = 64'($signed(hp0)) + 64'($signed(hp1));
            rsp_next.acc_data = acc_rd_in + dsum;
            rsp_next.acc_we = req_in.valid;
         end

         // idle or unknown operation writes nothing
         default:
         begin
            res = 32'h00000000; // no operation
         end
      endcase
      // sign of the low word fills the upper word
      rsp_next.gpr_data = {{32{res[31]}}, res};
   end

   // result register
   always_ff @(posedge clk_in)
   begin
      // synchronous clear to an idle response
      if (!rst_n_in)
         rsp_reg <= '0;
      // with the enable low every bit holds
      else if (ce_in)
         rsp_reg <= rsp_next;
   end

   // output comes straight from the result register
   assign rsp_out = rsp_reg;
endmodule

// ---- dsmd_datapath_checker.sv ----
`timescale 1ns/100ps
module dsmd_datapath_checker
   import dsmd_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   input wire dsmd_req_s req_in,
   input wire logic [63:0] acc_rd_in,
   input wire dsmd_rsp_s rsp_out
);
   dsmd_req_s rq_reg; // request behind the current response
   logic v_reg;
   logic [63:0] acc_reg, g;
   logic [15:0] x, y; // selected halfword pair
   logic [4:0] s;
   logic [16:0] u;
   logic [23:0] p;
   logic signed [63:0] d;
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   assign g = rsp_out.gpr_data;
   assign s = rq_reg.use_imm ? rq_reg.shift_amount_imm : rq_reg.source_a_reg[4:0];
   assign x = rq_reg.left ? rq_reg.source_a_reg[31:16] : rq_reg.source_a_reg[15:0];
   assign y = rq_reg.left ? rq_reg.source_b_reg[31:16] : rq_reg.source_b_reg[15:0];
   assign u = x[15:8] * y[15:8] + x[7:0] * y[7:0];
   assign p = x[15:8] * rq_reg.source_b_reg[31:16];
   assign d = $signed(rq_reg.source_a_reg[15:0]) * $signed(rq_reg.source_b_reg[15:0])
      + $signed(rq_reg.source_a_reg[31:16]) * $signed(rq_reg.source_b_reg[31:16]);
   // capture each accepted request
   always_ff @(posedge clk_in)
   begin
      // reset clears the valid flag even with the enable low
      if (!rst_n_in)
         v_reg <= 1'b0;
      else if (ce_in)
         v_reg <= req_in.valid;
      if (ce_in)
      begin
         rq_reg <= req_in;
         acc_reg <= acc_rd_in;
      end
   end
   property p_ext; rsp_out.gpr_we |-> g[63:32] == {32{g[31]}}; endproperty
   a_ext: assert property (p_ext) else $error("upper word");
   property p_qb; v_reg && rq_reg.op == DSMD_OP_SRA_QB && !rq_reg.round
      |-> g[31:24] == 8'($signed(rq_reg.source_b_reg[31:24]) >>> s[2:0]); endproperty
   a_qb: assert property (p_qb) else $error("byte shift");
   property p_rnd; v_reg && rq_reg.op == DSMD_OP_SRA_W && rq_reg.round && s != 0 |-> g[31:0] ==
      32'($signed({rq_reg.source_b_reg[31], rq_reg.source_b_reg} + (33'h1 << (s - 1))) >>> s);
   endproperty
   a_rnd: assert property (p_rnd) else $error("word round");
   property p_mub; v_reg && rq_reg.op == DSMD_OP_MUL_UBH
      |-> g[31:16] == (p > 24'hffff ? 16'hffff : p[15:0]); endproperty
   a_mub: assert property (p_mub) else $error("byte half product");
   property p_qrs; v_reg && rq_reg.op == DSMD_OP_MUL_QRS && rq_reg.source_a_reg[31:16] == 16'h8000
      && rq_reg.source_b_reg[31:16] == 16'h8000 |-> g[31:16] == 16'h7fff && !rsp_out.acc_we;
   endproperty
   a_qrs: assert property (p_qrs) else $error("q15 clamp");
   property p_qw; v_reg && rq_reg.op == DSMD_OP_MUL_QW |-> g[31:0] == (x == 16'h8000 &&
      y == 16'h8000 ? 32'h7fffffff : 32'($signed(x) * $signed(y)) << 1); endproperty
   a_qw: assert property (p_qw) else $error("q31 product");
   property p_dot; v_reg && rq_reg.op == DSMD_OP_DOT_UADD
      |-> rsp_out.acc_we && rsp_out.acc_data == acc_reg + u; endproperty
   a_dot: assert property (p_dot) else $error("byte dot");
   property p_dsub; v_reg && rq_reg.op == DSMD_OP_DOT_USUB
      |-> rsp_out.acc_we && rsp_out.acc_data == acc_reg - u; endproperty
   a_dsub: assert property (p_dsub) else $error("byte dot subtract");
   property p_sd; v_reg && rq_reg.op == DSMD_OP_DOT_SADD
      |-> rsp_out.acc_we && rsp_out.acc_data == acc_reg + d; endproperty
   a_sd: assert property (p_sd) else $error("half dot");
endmodule
bind dsmd_datapath dsmd_datapath_checker chk_u (.clk_in(clk_in), .rst_n_in(rst_n_in),
   .ce_in(ce_in), .req_in(req_in), .acc_rd_in(acc_rd_in), .rsp_out(rsp_out));

// ---- dsmd_params.svh ----
`ifndef DSMD_PARAMS_SVH
`define DSMD_PARAMS_SVH
// operand and accumulator widths
`define DSMD_WORD_W 32
`define DSMD_GPR_W 64
`define DSMD_ACC_W 64
`define DSMD_ACC_SEL_W 2
// shift amount field widths per element size
`define DSMD_SHAMT_QB_W 3
`define DSMD_SHAMT_PH_W 4
`define DSMD_SHAMT_W_W 5
// saturation and rounding constants, accumulator count
`define DSMD_U16_MAX 24'h00ffff
`define DSMD_Q15_RND 32'h00008000
`define DSMD_Q15_MAX 16'h7fff
`define DSMD_Q15_MIN 16'h8000
`define DSMD_Q31_MAX 32'h7fffffff
`define DSMD_NUM_ACC 4
`endif

// ---- dsmd_pipe_model.sv ----
`timescale 1ns/100ps
module dsmd_pipe_model
   import dsmd_pkg::*;
(
   input wire logic clk_in,
   input wire dsmd_req_s req_in,
   input wire dsmd_rsp_s rsp_in,
   output logic [63:0] acc_rd_out
);
   logic [63:0] acc_mem [4]; // accumulator file of the pipeline
   initial acc_mem = '{64'h10, 64'h0, 64'h0, 64'hfffffffffffffff0};
   assign acc_rd_out = acc_mem[req_in.acc_sel];
   // write back accumulator results
   always @(posedge clk_in)
      if (rsp_in.acc_we)
         acc_mem[rsp_in.acc_sel] <= rsp_in.acc_data;
endmodule

// ---- dsmd_pkg.sv ----
package dsmd_pkg;
   // operation select
   typedef enum logic [3:0]
   {
      DSMD_OP_NOP,
      DSMD_OP_SRA_QB,
      DSMD_OP_SRA_PH,
      DSMD_OP_SRA_W,
      DSMD_OP_MUL_UBH,
      DSMD_OP_MUL_QRS,
      DSMD_OP_MUL_QW,
      DSMD_OP_DOT_UADD,
      DSMD_OP_DOT_USUB,
      DSMD_OP_DOT_SADD
   } dsmd_op_e;
   // issued request
   typedef struct packed
   {
      logic valid;
      dsmd_op_e op;
      logic round;
      logic use_imm;
      logic left;
      logic [1:0] acc_sel;
      logic [4:0] shift_amount_imm;
      logic [31:0] source_a_reg;
      logic [31:0] source_b_reg;
   } dsmd_req_s;
   // returned result
   typedef struct packed
   {
      logic gpr_we;
      logic [63:0] gpr_data;
      logic acc_we;
      logic [1:0] acc_sel;
      logic [63:0] acc_data;
   } dsmd_rsp_s;
endpackage

// ---- dsmd_shift_multiply_datapath_tb_top.sv ----
`timescale 1ns/100ps
module dsmd_shift_multiply_datapath_tb_top;
   import dsmd_pkg::*;
   logic clk_in = 0, rst_n_in = 0, ce_in = 1;
   dsmd_req_s req_in = '0;
   logic [63:0] acc_rd;
   dsmd_rsp_s rsp_out;
   int n_errors = 0, samples_checked = 0;
   dsmd_datapath dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
      .req_in(req_in), .acc_rd_in(acc_rd), .rsp_out(rsp_out));
   dsmd_pipe_model pipe_u (.clk_in(clk_in), .req_in(req_in), .rsp_in(rsp_out),
      .acc_rd_out(acc_rd));
   initial forever #2.5 clk_in = ~clk_in;
   task automatic cmp(string n, logic [63:0] e, logic [63:0] s);
      samples_checked++;
      if (s !== e)
      begin
         n_errors++;
         $display("CHECK FAILED %s exp %h got %h", n, e, s);
      end
   endtask
   // flags are round, use_imm, left, acc_sel; one request, then its result
   task automatic go(dsmd_op_e o, logic [4:0] f, sh, logic [31:0] a, b, logic [63:0] e);
      @(negedge clk_in);
      req_in = {1'b1, o, f, sh, a, b};
      @(negedge clk_in);
      req_in.valid = 0;
      cmp(o.name(), e, o < DSMD_OP_DOT_UADD ? rsp_out.gpr_data : rsp_out.acc_data);
      cmp("gpr_we", {63'h0, o < DSMD_OP_DOT_UADD}, {63'h0, rsp_out.gpr_we});
      cmp("acc_we", {63'h0, o >= DSMD_OP_DOT_UADD}, {63'h0, rsp_out.acc_we});
      cmp("acc_sel", {62'h0, f[1:0]}, {62'h0, rsp_out.acc_sel});
   endtask
   task automatic t_shift();
      go(DSMD_OP_SRA_QB, 5'h08, 5'h3, 32'h0, 32'h807ff010, 64'hfffffffff00ffe02);
      go(DSMD_OP_SRA_QB, 5'h00, 5'h0, 32'hfffffffa, 32'h40404040, 64'h10101010);
      go(DSMD_OP_SRA_PH, 5'h10, 5'h0, 32'h14, 32'h80080018, 64'hfffffffff8010002);
      go(DSMD_OP_SRA_W, 5'h18, 5'h1, 32'h0, 32'h7fffffff, 64'h40000000);
   endtask
   task automatic t_mul();
      go(DSMD_OP_MUL_UBH, 5'h04, 5'h0, 32'hff020000, 32'h01027fff, 64'hfffffffffffffffe);
      go(DSMD_OP_MUL_UBH, 5'h00, 5'h0, 32'h0203, 32'h00100100, 64'h00200300);
      go(DSMD_OP_MUL_QRS, 5'h00, 5'h0, 32'h80004000, 32'h80004000, 64'h7fff2000);
      cmp("acc_we", 64'h0, {63'h0, rsp_out.acc_we});
      go(DSMD_OP_MUL_QW, 5'h00, 5'h0, 32'h8000, 32'h12348000, 64'h7fffffff);
      go(DSMD_OP_MUL_QW, 5'h04, 5'h0, 32'hc0000000, 32'h40000000, 64'hffffffffe0000000);
   endtask
   task automatic t_dot();
      go(DSMD_OP_DOT_UADD, 5'h00, 5'h0, 32'hff02, 32'hff03, 64'hfe17);
      go(DSMD_OP_DOT_USUB, 5'h04, 5'h0, 32'h01020000, 32'h03040000, 64'hfe0c);
      go(DSMD_OP_DOT_SADD, 5'h03, 5'h0, 32'hffff0002, 32'h00050003, 64'hfffffffffffffff1);
   endtask
   // clock enable freeze, then a reset in mid-run
   task automatic t_hold();
      @(negedge clk_in);
      ce_in = 0;
      req_in = {1'b1, DSMD_OP_SRA_W, 5'h08, 5'h4, 32'h0, 32'h00000100};
      @(negedge clk_in);
      cmp("frozen_we", 64'h0, {63'h0, rsp_out.gpr_we});
      ce_in = 1;
      @(negedge clk_in);
      cmp("thawed", 64'h10, rsp_out.gpr_data);
      req_in.valid = 0;
      rst_n_in = 0;
      @(negedge clk_in);
      cmp("mid_reset", 64'h0, rsp_out.gpr_data);
      rst_n_in = 1;
   endtask
   task automatic summarize();
      $display("errors %0d checks %0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // watchdog against a hang
   initial
   begin
      #2000;
      n_errors++;
      summarize();
   end
   initial
   begin
      repeat (8) @(negedge clk_in);
      cmp("reset", 64'h0, rsp_out.gpr_data);
      rst_n_in = 1;
      t_shift();
      t_mul();
      t_dot();
      t_hold();
      summarize();
   end
endmodule
